// [core/dcc_consts.vh]
// constants for the datapath condition and chaining slice
// assumes inclusion by core/dcc_slice.v, the slice monitor and the testbench
`ifndef DCC_CONSTS_VH
`define DCC_CONSTS_VH
// register byte offsets
`define DCC_OFS_ACC0    6'h00
`define DCC_OFS_ACC1    6'h04
`define DCC_OFS_DATA0   6'h08
`define DCC_OFS_DATA1   6'h0c
`define DCC_OFS_CTRL    6'h10
`define DCC_OFS_MASK    6'h14
`define DCC_OFS_OSEL    6'h18
`define DCC_OFS_COND    6'h1c
`define DCC_OFS_CAPT    6'h20
// control register fields
`define DCC_B_EXT_FB    0
`define DCC_B_PI_FORCE  1
`define DCC_B_PARALLEL_IN_DYNAMIC_ENABLE    2
`define DCC_B_CH_CMP0   3
`define DCC_B_CH_CMP1   4
`define DCC_B_CH_DET    5
`define DCC_B_CH_FB     6
`define DCC_B_CH_MSB    7
`define DCC_B_CH_CAP    8
`define DCC_B_CH_SHL    9
`define DCC_B_CH_SHR    10
`define DCC_F_MSB_LO    11
`define DCC_F_MSB_HI    13
`define DCC_F_SETA_LO   14
`define DCC_F_SETA_HI   15
`define DCC_F_SETB_LO   16
`define DCC_F_SETB_HI   17
`define DCC_F_CIA_LO    18
`define DCC_F_CIA_HI    19
`define DCC_F_CIB_LO    20
`define DCC_F_CIB_HI    21
`define DCC_CTRL_W      22
// reset values
`define DCC_RST_CTRL    22'h003800
`define DCC_RST_MASK    16'hffff
`define DCC_RST_OSEL    24'h000000
// per-cycle configuration word fields
`define DCC_D_FUNC_LO   13
`define DCC_D_FUNC_HI   15
`define DCC_D_SRCA      12
`define DCC_D_SRCB_LO   10
`define DCC_D_SRCB_HI   11
`define DCC_D_SHF_LO    8
`define DCC_D_SHF_HI    9
`define DCC_D_A0W_LO    6
`define DCC_D_A0W_HI    7
`define DCC_D_A1W_LO    4
`define DCC_D_A1W_HI    5
`define DCC_D_FBGATE    3
`define DCC_D_CISEL     2
`define DCC_D_CMPSEL    0
// detector constants
`define DCC_ALL_ZERO    8'h00
`define DCC_ALL_ONES    8'hff
`endif

// [core/dcc_slice.v]
// one 8-bit datapath slice: alu, conditions, compares, chaining
// assumes an avalon-mm master on clk and neighbours on the same clk
//
// Overview of operation
// - external feedback select takes feedback from carry input mux.
// - feedback gate bit still gates feedback into alu b operand.
// - gate bit clear forces feedback to one, b passes unchanged.
// - conditions come from accumulators, alu outputs and fifo status.
// - sixteen conditions: compares, detects, overflow, carry, msb, shift, fifo.
// - six condition outputs, each with own sixteen-way selector.
// - compare one fixed acc0 vs data0; compare two operands selectable.
// - each compare has 8-bit mask; reset leaves all bits compared.
// - code 00 a1/d1, 01 a1/a0, 10 a0/d1, 11 a0/a0.
// - two static operand codes; per-cycle bit picks set a or b.
// - equal chaining ands local equal with previous slice equal.
// - less chaining: local less or (local equal and chained less).
// - per accumulator all-zeros and all-ones detectors.
// - detect chaining ands local detect with chained detect.
// - overflow is carry into xor carry out of selected msb.
// - parallel output is always the srca-selected accumulator, acc0 or acc1, even when alu a takes the parallel input.
// - parallel-input force makes alu a operand the parallel input.
// - dynamic enable lets gate bit steer the parallel-input mux.
// - dedicated carry, shift, capture and condition chain signals.
// - chained capture snapshots all accumulators in one cycle.
// - conditions, capture, left shift go up; right shift goes down.
// - feedback chains upward; crc msb chains downward.
`include "dcc_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module dcc_slice (
    // clock and reset
    input  wire        clk,
    input  wire        arst_n,
    // avalon-mm slave
    input  wire [5:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    // per-cycle configuration word
    input  wire [15:0] dyn_cfg,
    // routed inputs
    input  wire [7:0]  parallel_input,
    input  wire        carry_routed,
    input  wire        shift_in,
    input  wire        capture_trigger,
    input  wire [7:0]  fifo_first_data,
    input  wire [7:0]  fifo_second_data,
    input  wire        fifo_first_block_status,
    input  wire        fifo_second_block_status,
    input  wire        fifo_first_bus_status,
    input  wire        fifo_second_bus_status,
    // routed outputs
    output wire [7:0]  parallel_output,
    output reg  [5:0]  cond_out,
    // chain from less significant slice
    input  wire [7:0]  chain_cond_in,
    input  wire        chain_carry_in,
    input  wire        chain_shl_in,
    input  wire        chain_capture_in,
    input  wire        chain_fb_in,
    // chain to more significant slice
    output wire [7:0]  chain_cond_out,
    output wire        chain_carry_out,
    output wire        chain_shl_out,
    output wire        chain_capture_out,
    output wire        chain_fb_out,
    // chain from more significant slice
    input  wire        chain_shr_in,
    input  wire        chain_msb_in,
    // chain to less significant slice
    output wire        chain_shr_out,
    output wire        chain_msb_out
);

    reg  [7:0]  acc0_reg;
    reg  [7:0]  acc1_reg;
    reg  [7:0]  data0_reg;
    reg  [7:0]  data1_reg;
    reg  [`DCC_CTRL_W-1:0] ctrl_reg;
    reg  [15:0] mask_reg;
    reg  [23:0] osel_reg;
    reg  [15:0] capt_reg;
    reg         rd_done_reg;
    reg  [7:0]  acc0_next;
    reg  [7:0]  acc1_next;
    reg  [7:0]  src_b;
    reg  [1:0]  ci_code;
    reg         carry_in;
    reg  [7:0]  y_op;
    reg         c_op;
    reg  [7:0]  alu_out;
    reg  [7:0]  shf_out;
    reg         shift_out;
    reg  [7:0]  cmp1_x;
    reg  [7:0]  cmp1_y;
    reg  [31:0] rd_next;

    wire [2:0]  func     = dyn_cfg[`DCC_D_FUNC_HI:`DCC_D_FUNC_LO];
    wire [1:0]  srcb_sel = dyn_cfg[`DCC_D_SRCB_HI:`DCC_D_SRCB_LO];
    wire [1:0]  shf_sel  = dyn_cfg[`DCC_D_SHF_HI:`DCC_D_SHF_LO];
    wire [1:0]  a0w_sel  = dyn_cfg[`DCC_D_A0W_HI:`DCC_D_A0W_LO];
    wire [1:0]  a1w_sel  = dyn_cfg[`DCC_D_A1W_HI:`DCC_D_A1W_LO];
    wire        fb_gate  = dyn_cfg[`DCC_D_FBGATE];
    wire [2:0]  msb_sel  = ctrl_reg[`DCC_F_MSB_HI:`DCC_F_MSB_LO];
    wire [1:0]  cmp_code;
    wire [7:0]  acc_sel;
    wire [7:0]  alu_a;
    wire        msb_val;
    wire        fb_raw;
    wire        fb_eff;
    wire [8:0]  sum;
    wire [8:0]  cvec;
    wire        ovf;
    wire        cout_msb;
    wire [7:0]  loc;
    wire [15:0] cond;
    wire [7:0]  m0;
    wire [7:0]  m1;
    wire        cap_now;
    wire        bus_wr;

    assign acc_sel = dyn_cfg[`DCC_D_SRCA] ? acc1_reg : acc0_reg;
    assign parallel_output = acc_sel;
    assign alu_a = ctrl_reg[`DCC_B_PI_FORCE] ? parallel_input :
                   (ctrl_reg[`DCC_B_PARALLEL_IN_DYNAMIC_ENABLE] && fb_gate) ?
                   parallel_input : acc_sel;

    always @* begin
        ci_code = dyn_cfg[`DCC_D_CISEL] ?
                  ctrl_reg[`DCC_F_CIB_HI:`DCC_F_CIB_LO] :
                  ctrl_reg[`DCC_F_CIA_HI:`DCC_F_CIA_LO];
        case (ci_code)
            2'h0: carry_in = 1'b0;
            2'h1: carry_in = 1'b1;
            2'h2: carry_in = carry_routed;
            2'h3: carry_in = chain_carry_in;
            default: carry_in = 1'b0;
        endcase
    end

    assign msb_val = ctrl_reg[`DCC_B_CH_MSB] ? chain_msb_in :
                     alu_a[msb_sel];
    assign chain_msb_out = msb_val;
    // external mode bypasses the built-in msb xor shift-in term
    assign fb_raw = ctrl_reg[`DCC_B_EXT_FB] ? carry_in :
                    ctrl_reg[`DCC_B_CH_FB] ? chain_fb_in :
                    (shift_in ^ msb_val);
    assign chain_fb_out = fb_raw;
    assign fb_eff = fb_gate ? fb_raw : 1'b1;

    always @* begin
        case (srcb_sel)
            2'h0: src_b = data0_reg;
            2'h1: src_b = data1_reg;
            2'h2: src_b = acc0_reg;
            default: src_b = acc1_reg;
        endcase
        src_b = src_b & {8{fb_eff}};
    end

    always @* begin
        y_op = 8'h00;
        c_op = 1'b0;
        case (func)
            3'h1: c_op = 1'b1;
            3'h2: y_op = `DCC_ALL_ONES;
            3'h3: begin
                y_op = src_b;
                c_op = carry_in;
            end
            3'h4: begin
                y_op = ~src_b;
                c_op = 1'b1;
            end
            default: y_op = 8'h00;
        endcase
    end

    assign sum = {1'b0, alu_a} + {1'b0, y_op} + {8'h00, c_op};
    assign cvec = {sum[8], alu_a ^ y_op ^ sum[7:0]};
    assign cout_msb = cvec[{1'b0, msb_sel} + 4'h1];
    assign ovf = cout_msb ^ cvec[msb_sel];
    assign chain_carry_out = cout_msb;

    always @* begin
        case (func)
            3'h0: alu_out = alu_a;
            3'h1, 3'h2, 3'h3, 3'h4: alu_out = sum[7:0];
            3'h5: alu_out = alu_a ^ src_b;
            3'h6: alu_out = alu_a & src_b;
            default: alu_out = alu_a | src_b;
        endcase
    end

    // shifter; chained shift data keeps multi-slice shifts in one cycle
    always @* begin
        case (shf_sel)
            2'h1: begin
                shf_out = {alu_out[6:0], ctrl_reg[`DCC_B_CH_SHL] ?
                           chain_shl_in : shift_in};
                shift_out = alu_out[7];
            end
            2'h2: begin
                shf_out = {ctrl_reg[`DCC_B_CH_SHR] ?
                           chain_shr_in : shift_in, alu_out[7:1]};
                shift_out = alu_out[0];
            end
            2'h3: begin
                shf_out = {alu_out[3:0], alu_out[7:4]};
                shift_out = 1'b0;
            end
            default: begin
                shf_out = alu_out;
                shift_out = 1'b0;
            end
        endcase
    end
    assign chain_shl_out = alu_out[7];
    assign chain_shr_out = alu_out[0];

    assign m0 = mask_reg[7:0];
    assign m1 = mask_reg[15:8];
    assign cmp_code = dyn_cfg[`DCC_D_CMPSEL] ?
                      ctrl_reg[`DCC_F_SETB_HI:`DCC_F_SETB_LO] :
                      ctrl_reg[`DCC_F_SETA_HI:`DCC_F_SETA_LO];
    always @* begin
        case (cmp_code)
            2'h0: begin
                cmp1_x = acc1_reg;
                cmp1_y = data1_reg;
            end
            2'h1: begin
                cmp1_x = acc1_reg;
                cmp1_y = acc0_reg;
            end
            2'h2: begin
                cmp1_x = acc0_reg;
                cmp1_y = data1_reg;
            end
            default: begin
                cmp1_x = acc0_reg;
                cmp1_y = acc0_reg;
            end
        endcase
    end

    assign loc[0] = (acc0_reg & m0) == (data0_reg & m0);
    assign loc[1] = (acc0_reg & m0) <  (data0_reg & m0);
    assign loc[2] = acc0_reg == `DCC_ALL_ZERO;
    assign loc[3] = acc0_reg == `DCC_ALL_ONES;
    assign loc[4] = (cmp1_x & m1) == (cmp1_y & m1);
    assign loc[5] = (cmp1_x & m1) <  (cmp1_y & m1);
    assign loc[6] = acc1_reg == `DCC_ALL_ZERO;
    assign loc[7] = acc1_reg == `DCC_ALL_ONES;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_chain
            wire ch_cmp = g ? ctrl_reg[`DCC_B_CH_CMP1] :
                              ctrl_reg[`DCC_B_CH_CMP0];
            wire ch_det = ctrl_reg[`DCC_B_CH_DET];
            assign chain_cond_out[4*g] = ch_cmp ?
                loc[4*g] & chain_cond_in[4*g] : loc[4*g];
            assign chain_cond_out[4*g+1] = ch_cmp ?
                loc[4*g+1] | (loc[4*g] & chain_cond_in[4*g+1]) :
                loc[4*g+1];
            assign chain_cond_out[4*g+2] = ch_det ?
                loc[4*g+2] & chain_cond_in[4*g+2] : loc[4*g+2];
            assign chain_cond_out[4*g+3] = ch_det ?
                loc[4*g+3] & chain_cond_in[4*g+3] : loc[4*g+3];
        end
    endgenerate

    assign cond = {fifo_second_bus_status, fifo_first_bus_status,
                   fifo_second_block_status, fifo_first_block_status,
                   shift_out, msb_val, cout_msb, ovf,
                   chain_cond_out};

    generate
        for (g = 0; g < 6; g = g + 1) begin : g_osel
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    cond_out[g] <= 1'b0;
                end else begin
                    cond_out[g] <= cond[osel_reg[4*g+3:4*g]];
                end
            end
        end
    endgenerate

    assign cap_now = ctrl_reg[`DCC_B_CH_CAP] ? chain_capture_in :
                     capture_trigger;
    assign chain_capture_out = cap_now;

    assign bus_wr = write;
    always @* begin
        case (a0w_sel)
            2'h1: acc0_next = shf_out;
            2'h2: acc0_next = data0_reg;
            2'h3: acc0_next = fifo_first_data;
            default: acc0_next = acc0_reg;
        endcase
        case (a1w_sel)
            2'h1: acc1_next = shf_out;
            2'h2: acc1_next = data1_reg;
            2'h3: acc1_next = fifo_second_data;
            default: acc1_next = acc1_reg;
        endcase
        if (bus_wr && address == `DCC_OFS_ACC0) begin
            acc0_next = writedata[7:0];
        end
        if (bus_wr && address == `DCC_OFS_ACC1) begin
            acc1_next = writedata[7:0];
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc0_reg  <= 8'h00;
            acc1_reg  <= 8'h00;
            capt_reg  <= 16'h0000;
        end else begin
            acc0_reg <= acc0_next;
            acc1_reg <= acc1_next;
            if (cap_now) begin
                capt_reg <= {acc1_reg, acc0_reg};
            end
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data0_reg <= 8'h00;
            data1_reg <= 8'h00;
            ctrl_reg  <= `DCC_RST_CTRL;
            mask_reg  <= `DCC_RST_MASK;
            osel_reg  <= `DCC_RST_OSEL;
        end else if (bus_wr) begin
            case (address)
                `DCC_OFS_DATA0: data0_reg <= writedata[7:0];
                `DCC_OFS_DATA1: data1_reg <= writedata[7:0];
                `DCC_OFS_CTRL:
                    ctrl_reg <= writedata[`DCC_CTRL_W-1:0];
                `DCC_OFS_MASK:  mask_reg <= writedata[15:0];
                `DCC_OFS_OSEL:  osel_reg <= writedata[23:0];
                default: ;
            endcase
        end
    end

    assign waitrequest = read & ~rd_done_reg;

    always @* begin
        case (address)
            `DCC_OFS_ACC0:  rd_next = {24'h000000, acc0_reg};
            `DCC_OFS_ACC1:  rd_next = {24'h000000, acc1_reg};
            `DCC_OFS_DATA0: rd_next = {24'h000000, data0_reg};
            `DCC_OFS_DATA1: rd_next = {24'h000000, data1_reg};
            `DCC_OFS_CTRL:  rd_next = {10'h000, ctrl_reg};
            `DCC_OFS_MASK:  rd_next = {16'h0000, mask_reg};
            `DCC_OFS_OSEL:  rd_next = {8'h00, osel_reg};
            `DCC_OFS_COND:  rd_next = {16'h0000, cond};
            `DCC_OFS_CAPT:  rd_next = {16'h0000, capt_reg};
            default:        rd_next = 32'h00000000;
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            readdata    <= 32'h00000000;
            rd_done_reg <= 1'b0;
        end else begin
            if (read && !rd_done_reg) begin
                readdata    <= rd_next;
                rd_done_reg <= 1'b1;
            end else begin
                rd_done_reg <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// [verification/dcc_neighbours.sv]
// neighbour slices on both sides of the slice under test
// assumes the bench sets what the lower neighbour presents
`timescale 1ns/1ns
`default_nettype none
module dcc_neighbours (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // lower neighbour state
    input  wire logic [7:0] lo_cond,
    input  wire logic       lo_cap,
    // chain into the slice
    output logic [7:0]      chain_cond_in,
    output logic            chain_carry_in,
    output logic            chain_shl_in,
    output logic            chain_capture_in,
    output logic            chain_fb_in,
    output logic            chain_shr_in,
    output logic            chain_msb_in
);
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chain_cond_in    <= 8'h00;
            chain_capture_in <= 1'b0;
            chain_shl_in     <= 1'b0;
            chain_carry_in   <= 1'b0;
            chain_fb_in      <= 1'b0;
            chain_shr_in     <= 1'b1;
            chain_msb_in     <= 1'b1;
        end else begin
            chain_cond_in    <= lo_cond;
            chain_capture_in <= lo_cap;
            chain_shl_in     <= ~chain_shl_in;
            chain_carry_in   <= ~chain_carry_in;
            chain_fb_in      <= chain_carry_in;
            chain_shr_in     <= ~chain_shr_in;
            chain_msb_in     <= chain_shr_in;
        end
    end
endmodule
`default_nettype wire

// [verification/dcc_slice_monitor.sv]
// assertion checker for the datapath condition and chaining slice
// assumes a bind onto dcc_slice; static bits are shadowed from bus writes
`include "dcc_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module dcc_slice_monitor (
    // clock and reset
    input wire        clk,
    input wire        arst_n,
    // avalon-mm slave
    input wire [5:0]  address,
    input wire        read,
    input wire        write,
    input wire [31:0] writedata,
    input wire        waitrequest,
    // conditions
    input wire        fifo_first_block_status,
    input wire        fifo_second_block_status,
    input wire        fifo_first_bus_status,
    input wire        fifo_second_bus_status,
    input wire [5:0]  cond_out,
    input wire [7:0]  chain_cond_in,
    input wire [7:0]  chain_cond_out
);
    reg  [21:0] ctrl_reg;
    reg  [23:0] osel_reg;
    reg  [1:0]  exp_reg;
    reg  [1:0]  known_reg;
    wire [15:0] cond_vec = {fifo_second_bus_status, fifo_first_bus_status,
                            fifo_second_block_status, fifo_first_block_status,
                            4'h0, chain_cond_out};
    wire [3:0]  sel_first = osel_reg[3:0];
    wire [3:0]  sel_last  = osel_reg[23:20];
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg  <= `DCC_RST_CTRL;
            osel_reg  <= `DCC_RST_OSEL;
            exp_reg   <= 2'h0;
            known_reg <= 2'h0;
        end else begin
            if (write && !waitrequest && address == `DCC_OFS_CTRL)
                ctrl_reg <= writedata[21:0];
            if (write && !waitrequest && address == `DCC_OFS_OSEL)
                osel_reg <= writedata[23:0];
            exp_reg   <= {cond_vec[sel_last], cond_vec[sel_first]};
            known_reg <= {sel_last[3:2] != 2'b10, sel_first[3:2] != 2'b10};
        end
    end
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    a_eq_first_chain: assert property (
        ctrl_reg[3] && !chain_cond_in[0] |-> !chain_cond_out[0])
        else $error("eq0 chain");
    a_eq_second_chain: assert property (
        ctrl_reg[4] && !chain_cond_in[4] |-> !chain_cond_out[4])
        else $error("eq1 chain");
    a_less_chain: assert property (
        ctrl_reg[3] && chain_cond_out[0] |-> chain_cond_out[1] == chain_cond_in[1])
        else $error("lt chain");
    a_zero_chain: assert property (
        ctrl_reg[5] && !chain_cond_in[2] |-> !chain_cond_out[2])
        else $error("z0 chain");
    a_detect_exclusive: assert property (
        !ctrl_reg[5] |-> !(chain_cond_out[2] && chain_cond_out[3]) &&
                         !(chain_cond_out[6] && chain_cond_out[7]))
        else $error("detect clash");
    a_compare_exclusive: assert property (
        !ctrl_reg[3] |-> !(chain_cond_out[0] && chain_cond_out[1]))
        else $error("compare clash");
    a_route_first: assert property (
        known_reg[0] |-> cond_out[0] == exp_reg[0])
        else $error("route out0");
    a_route_last: assert property (
        known_reg[1] |-> cond_out[5] == exp_reg[1])
        else $error("route out5");
    a_read_answer: assert property (
        $rose(read) |-> waitrequest ##1 !waitrequest)
        else $error("read latency");
    a_write_nowait: assert property (write |-> !waitrequest)
        else $error("write stall");
    c_less_chained: cover property (ctrl_reg[3] && chain_cond_out[1]);
    c_fifo_routed: cover property (sel_first == 4'hc && cond_out[0]);
    c_read_done: cover property (read && !waitrequest);
endmodule
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the condition and chaining slice
// assumes dcc_slice, its constants header and the neighbour model
`include "dcc_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        clk = 1'b0, arst_n = 1'b0, read = 1'b0, write = 1'b0;
    logic        carry_routed = 1'b0, capture_trigger = 1'b0, lo_cap = 1'b0;
    logic        waitrequest;
    logic [5:0]  address = 6'h00;
    logic [31:0] writedata = 32'h0, readdata, rv;
    logic [15:0] dyn_cfg = 16'h0;
    logic [7:0]  parallel_input = 8'h00, lo_cond = 8'h00;
    logic [3:0]  fst = 4'h0;
    logic [7:0]  parallel_output, chain_cond_in, chain_cond_out, x, y;
    logic [5:0]  cond_out;
    logic        chain_carry_in, chain_shl_in, chain_capture_in;
    logic        chain_fb_in, chain_shr_in, chain_msb_in;
    logic [7:0]  pat [4] = '{8'h00, 8'hff, 8'h55, 8'haa};
    int          err_total = 0;
    int          checked = 0;
    int          k;
    dcc_slice dcc_slice_i (
        .clk, .arst_n, .address, .read, .write, .writedata, .readdata,
        .waitrequest, .dyn_cfg, .parallel_input, .carry_routed,
        .shift_in(1'b0), .capture_trigger, .fifo_first_data(8'h00),
        .fifo_second_data(8'h00), .fifo_first_block_status(fst[0]),
        .fifo_second_block_status(fst[1]), .fifo_first_bus_status(fst[2]),
        .fifo_second_bus_status(fst[3]), .parallel_output, .cond_out,
        .chain_cond_in, .chain_carry_in, .chain_shl_in, .chain_capture_in,
        .chain_fb_in, .chain_cond_out, .chain_carry_out(),
        .chain_shl_out(), .chain_capture_out(), .chain_fb_out(),
        .chain_shr_in, .chain_msb_in, .chain_shr_out(), .chain_msb_out());
    dcc_neighbours dcc_neighbours_i (
        .clk, .arst_n, .lo_cond, .lo_cap, .chain_cond_in, .chain_carry_in,
        .chain_shl_in, .chain_capture_in, .chain_fb_in, .chain_shr_in,
        .chain_msb_in);
    always #50 clk = ~clk;
    task automatic summarize;
        if (err_total == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // held until waitrequest low at an edge
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d);
        int   n;
        logic ws;
        n = 0;
        address <= a;
        writedata <= d;
        read <= !w;
        write <= w;
        do begin
            @(negedge clk);
            ws = waitrequest;
            rv = readdata;
            @(posedge clk);
            n++;
        end while (ws);
        chk("wait states", {31'h0, !w}, n - 1);
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [5:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    function automatic logic [1:0] ovc(input logic [7:0] a, b, input int m);
        logic [8:0] hi, lo;
        logic [7:0] msk;
        msk = 8'hff >> (7 - m);
        hi = (a & msk) + (b & msk);
        lo = (a & (msk >> 1)) + (b & (msk >> 1));
        return {hi[m + 1], hi[m + 1] ^ lo[m]};
    endfunction
    initial begin
        tk(8);
        arst_n <= 1'b1;
        tk(1);
        rd(`DCC_OFS_CTRL);
        chk("control", `DCC_RST_CTRL, rv);
        rd(`DCC_OFS_MASK);
        chk("mask", `DCC_RST_MASK, rv);
        rd(`DCC_OFS_OSEL);
        chk("output select", `DCC_RST_OSEL, rv);
        rd(6'h3c);
        chk("unmapped", 32'h0, rv);
        wr(`DCC_OFS_ACC0, 8'h03);
        wr(`DCC_OFS_DATA0, 8'h03);
        wr(`DCC_OFS_ACC1, 8'h07);
        wr(`DCC_OFS_DATA1, 8'h07);
        for (int c = 0; c < 4; c++) begin
            wr(`DCC_OFS_CTRL, `DCC_RST_CTRL | (c << 14) | ((3 - c) << 16));
            for (int s = 0; s < 2; s++) begin
                k = s ? 3 - c : c;
                x = k[1] ? 8'h03 : 8'h07;
                y = k[0] ? 8'h03 : 8'h07;
                dyn_cfg <= {15'h0, s[0]};
                rd(`DCC_OFS_COND);
                chk("compares", {x < y, x == y, 4'h1}, rv[5:0]);
            end
        end
        dyn_cfg <= 16'h0;
        wr(`DCC_OFS_ACC0, 8'h13);
        wr(`DCC_OFS_DATA0, 8'h23);
        rd(`DCC_OFS_COND);
        chk("first compare", 2'b10, rv[1:0]);
        wr(`DCC_OFS_MASK, 16'hff0f);
        rd(`DCC_OFS_COND);
        chk("masked compare", 2'b01, rv[1:0]);
        wr(`DCC_OFS_MASK, `DCC_RST_MASK);
        for (int i = 0; i < 2; i++) begin
            wr(`DCC_OFS_ACC0, pat[i]);
            wr(`DCC_OFS_ACC1, pat[1 - i]);
            rd(`DCC_OFS_COND);
            chk("detectors", i ? 4'h6 : 4'h9, {rv[7:6], rv[3:2]});
        end
        wr(`DCC_OFS_CTRL, `DCC_RST_CTRL | 22'h38);
        wr(`DCC_OFS_ACC0, 8'h00);
        wr(`DCC_OFS_DATA0, 8'h00);
        wr(`DCC_OFS_ACC1, 8'h20);
        wr(`DCC_OFS_DATA1, 8'h30);
        for (int i = 0; i < 4; i++) begin
            lo_cond <= pat[i];
            tk(2);
            #1 chk("chain out", {5'h04, pat[i][2:0]}, chain_cond_out);
            tk(1);
        end
        wr(`DCC_OFS_CTRL, `DCC_RST_CTRL);
        wr(`DCC_OFS_OSEL, 24'h21fedc);
        rd(`DCC_OFS_OSEL);
        chk("output select", 24'h21fedc, rv);
        for (int i = 2; i < 4; i++) begin
            fst <= pat[i][3:0];
            tk(2);
            #1 chk("cond out", {2'b10, pat[i][3:0]}, cond_out);
            tk(1);
        end
        wr(`DCC_OFS_ACC0, 8'h5a);
        wr(`DCC_OFS_ACC1, 8'hc3);
        for (int s = 0; s < 2; s++) begin
            dyn_cfg <= {3'h0, s[0], 12'h0};
            tk(1);
            #1 chk("parallel output", s ? 8'hc3 : 8'h5a, parallel_output);
            tk(1);
        end
        parallel_input <= 8'h6e;
        for (int i = 0; i < 3; i++) begin
            wr(`DCC_OFS_CTRL, `DCC_RST_CTRL | (i ? 22'h4 : 22'h2));
            wr(`DCC_OFS_ACC0, 8'h11);
            dyn_cfg <= {8'h00, 2'b01, 2'b00, i == 2, 3'h0};
            tk(1);
            dyn_cfg <= 16'h0;
            rd(`DCC_OFS_ACC0);
            chk("parallel in", i == 1 ? 8'h11 : 8'h6e, rv[7:0]);
        end
        carry_routed <= 1'b1;
        wr(`DCC_OFS_DATA0, 8'h33);
        for (int i = 0; i < 4; i++) begin
            k = (i == 3) ? 2 : (i == 1);
            wr(`DCC_OFS_CTRL, `DCC_RST_CTRL | 22'h1 | (k << 18));
            wr(`DCC_OFS_ACC0, 8'h0f);
            dyn_cfg <= {3'h5, 5'h00, 2'b01, 2'b00, i != 2, 3'h0};
            tk(1);
            dyn_cfg <= 16'h0;
            rd(`DCC_OFS_ACC0);
            chk("feedback xor", i ? 8'h3c : 8'h0f, rv[7:0]);
        end
        dyn_cfg <= {3'h3, 13'h0};
        for (int i = 0; i < 4; i++) begin
            k = (i == 3) ? 3 : 7;
            x = pat[i] ^ 8'h80;
            y = (i == 2) ? 8'h80 : 8'h01;
            wr(`DCC_OFS_CTRL, k << 11);
            wr(`DCC_OFS_ACC0, (i == 3) ? 8'h07 : x - 8'h01);
            wr(`DCC_OFS_DATA0, y);
            rd(`DCC_OFS_COND);
            chk("overflow", ovc((i == 3) ? 8'h07 : x - 8'h01, y, k), rv[9:8]);
        end
        dyn_cfg <= 16'h0;
        for (int i = 0; i < 2; i++) begin
            wr(`DCC_OFS_CTRL, `DCC_RST_CTRL | (i << 8));
            wr(`DCC_OFS_ACC0, pat[i + 2]);
            wr(`DCC_OFS_ACC1, pat[3 - i]);
            capture_trigger <= !i;
            lo_cap <= i[0];
            tk(1);
            capture_trigger <= 1'b0;
            lo_cap <= 1'b0;
            tk(2);
            wr(`DCC_OFS_ACC0, 8'h99);
            rd(`DCC_OFS_CAPT);
            chk("capture", {pat[3 - i], pat[i + 2]}, rv[15:0]);
        end
        summarize();
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        summarize();
    end
endmodule
bind dcc_slice dcc_slice_monitor dcc_slice_monitor_i (
    .clk, .arst_n, .address, .read, .write, .writedata, .waitrequest,
    .fifo_first_block_status, .fifo_second_block_status,
    .fifo_first_bus_status, .fifo_second_bus_status,
    .cond_out, .chain_cond_in, .chain_cond_out);
`default_nettype wire
